// File: pdcl_params.svh
`ifndef PDCL_PARAMS_SVH
`define PDCL_PARAMS_SVH

// frame length and flag positions, in load clock numbers (first is 1)
`define PDCL_FRAME_LEN       8'hE1
`define PDCL_POS_PRESET_EN   8'h02
`define PDCL_POS_SEL_HI      8'h03
`define PDCL_POS_SEL_LO      8'h04
`define PDCL_POS_LOW_RATE    8'h05
`define PDCL_POS_SLOT_FIRST  8'h06
`define PDCL_POS_SLOT_LAST   8'h08
`define PDCL_POS_INVERT      8'h09
`define PDCL_POS_DC_MODE     8'h0A
`define PDCL_POS_PLL_FIRST   8'h0E
`define PDCL_POS_PLL_LAST    8'h13
`define PDCL_POS_RF_FIRST    8'h14
`define PDCL_POS_RF_LAST     8'h19
`define PDCL_POS_FILT_EN     8'h1A
`define PDCL_POS_FILT_FIRST  8'h1B
`define PDCL_POS_FILT_LAST   8'h1C
`define PDCL_POS_THR_FIRST   8'h1D
`define PDCL_POS_THR_LAST    8'h1F
// address field starts, one per 32-clock code word
`define PDCL_POS_ADDR_BASE   8'h21
`define PDCL_ADDR_STRIDE     8'h20
`define PDCL_ADDR_BITS       8'h12
`define PDCL_ADDR_SLOTS      6
`endif

// File: pdcl_pkg.sv
package pdcl_pkg;
    typedef enum logic [2:0] {
        PDCL_IDLE = 3'b001,
        PDCL_LOAD = 3'b010,
        PDCL_DONE = 3'b100
    } pdcl_state_t;

    typedef struct packed {
        logic [5:0] pll;
        logic [5:0] rf;
        logic       filt_en;
        logic [1:0] filt_char;
        logic [2:0] thr;
    } pdcl_timing_t;
endpackage : pdcl_pkg

// File: pdcl_config_loader.sv
`timescale 1ns/1ps
`include "pdcl_params.svh"
module pdcl_config_loader
    import pdcl_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    input  wire logic        load_clk_in,
    input  wire logic        load_data_in,
    input  wire logic        radio_signal_input_in,
    output logic             config_done_out,
    output logic             preset_enable_out,
    output logic             preset_select_hi_out,
    output logic             preset_select_lo_out,
    output logic             low_rate_select_out,
    output logic [2:0]       frame_slot_number_out,
    output logic             input_polarity_invert_out,
    output logic             dc_adjust_output_out,
    output logic [5:0]       pll_lead_time_out,
    output logic [5:0]       rf_lead_time_out,
    output logic             filter_enable_out,
    output logic [1:0]       filter_characteristic_out,
    output logic [2:0]       rate_error_threshold_out,
    output logic             radio_signal_decode_out,
    output logic [17:0]      address_slot_a_out,
    output logic [17:0]      address_slot_b_out,
    output logic [17:0]      address_slot_c_out,
    output logic [17:0]      address_slot_d_out,
    output logic [17:0]      address_slot_e_out,
    output logic [17:0]      address_slot_f_out
);

    // preset table, index {sel_hi, sel_lo, low_rate}
    function automatic pdcl_timing_t preset_lookup(input logic [2:0] idx);
        pdcl_timing_t p;
        p = '0;
        case (idx)
            3'h0: p = {6'h3D, 6'h0A, 1'b1, 2'h1, 3'h1};
            3'h2: p = {6'h3D, 6'h0C, 1'b1, 2'h1, 3'h1};
            3'h4: p = {6'h3D, 6'h0E, 1'b1, 2'h1, 3'h1};
            3'h6: p = {6'h3D, 6'h11, 1'b0, 2'h0, 3'h1};
            3'h1: p = {6'h1B, 6'h04, 1'b1, 2'h1, 3'h1};
            3'h3: p = {6'h1B, 6'h05, 1'b1, 2'h1, 3'h1};
            3'h5: p = {6'h1B, 6'h06, 1'b1, 2'h1, 3'h1};
            3'h7: p = {6'h1B, 6'h07, 1'b0, 2'h0, 3'h1};
            default: p = '0;
        endcase
        return p;
    endfunction : preset_lookup

    // true when pos lies in [first, last]
    function automatic logic in_field(input logic [7:0] pos,
                                      input logic [7:0] first,
                                      input logic [7:0] last);
        return (pos >= first) && (pos <= last);
    endfunction : in_field

    // two-flop synchronisers; first stages read only by second
    logic [1:0] clk_sync_r;
    logic [1:0] dat_sync_r;
    logic [1:0] sig_sync_r;
    logic       clk_prev_r;

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            clk_sync_r <= 2'h0;
            dat_sync_r <= 2'h0;
            sig_sync_r <= 2'h0;
            clk_prev_r <= 1'b0;
        end else begin
            clk_sync_r <= {clk_sync_r[0], load_clk_in};
            dat_sync_r <= {dat_sync_r[0], load_data_in};
            sig_sync_r <= {sig_sync_r[0], radio_signal_input_in};
            clk_prev_r <= clk_sync_r[1];
        end
    end

    // host changes data on falling edge, so rising edge is mid-bit
    logic sample_edge;
    assign sample_edge = clk_sync_r[1] & ~clk_prev_r;

    pdcl_state_t state_r;
    pdcl_state_t state_nxt;
    logic [7:0]  pos_r;      // number of the clock being received
    logic [7:0]  pos_nxt;
    logic        last_bit;

    assign last_bit = (pos_r == `PDCL_FRAME_LEN);

    // loader sequencing; extra clocks after 225 are ignored
    always_comb begin
        state_nxt = state_r;
        pos_nxt   = pos_r;
        case (state_r)
            PDCL_IDLE: begin
                state_nxt = PDCL_LOAD;
                pos_nxt   = 8'h01;
            end
            PDCL_LOAD: begin
                if (sample_edge) begin
                    if (last_bit) begin
                        state_nxt = PDCL_DONE;
                    end else begin
                        pos_nxt = pos_r + 8'h01;
                    end
                end
            end
            PDCL_DONE: begin
                state_nxt = PDCL_DONE;
            end
            default: begin
                state_nxt = PDCL_IDLE;
                pos_nxt   = 8'h00;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            state_r <= PDCL_IDLE;
            pos_r   <= 8'h00;
        end else begin
            state_r <= state_nxt;
            pos_r   <= pos_nxt;
        end
    end

    logic take;
    assign take = (state_r == PDCL_LOAD) && sample_edge;

    // flag bits; msb arrives first so fields shift left
    logic        preset_en_r;
    logic [1:0]  sel_r;
    logic        low_rate_r;
    logic [2:0]  slot_r;
    logic        invert_r;
    logic        dc_mode_r;
    pdcl_timing_t tx_timing_r;
    logic        bit_in;

    assign bit_in = dat_sync_r[1];

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            preset_en_r <= 1'b0;
            sel_r       <= 2'h0;
            low_rate_r  <= 1'b0;
            slot_r      <= 3'h0;
            invert_r    <= 1'b0;
            dc_mode_r   <= 1'b0;
            tx_timing_r <= '0;
        end else if (take) begin
            if (pos_r == `PDCL_POS_PRESET_EN)
                preset_en_r <= bit_in;
            if (pos_r == `PDCL_POS_SEL_HI)
                sel_r[1] <= bit_in;
            if (pos_r == `PDCL_POS_SEL_LO)
                sel_r[0] <= bit_in;
            if (pos_r == `PDCL_POS_LOW_RATE)
                low_rate_r <= bit_in;
            if (in_field(pos_r, `PDCL_POS_SLOT_FIRST, `PDCL_POS_SLOT_LAST))
                slot_r <= {slot_r[1:0], bit_in};
            if (pos_r == `PDCL_POS_INVERT)
                invert_r <= bit_in;
            if (pos_r == `PDCL_POS_DC_MODE)
                dc_mode_r <= bit_in;
            if (in_field(pos_r, `PDCL_POS_PLL_FIRST, `PDCL_POS_PLL_LAST))
                tx_timing_r.pll <= {tx_timing_r.pll[4:0], bit_in};
            if (in_field(pos_r, `PDCL_POS_RF_FIRST, `PDCL_POS_RF_LAST))
                tx_timing_r.rf <= {tx_timing_r.rf[4:0], bit_in};
            if (pos_r == `PDCL_POS_FILT_EN)
                tx_timing_r.filt_en <= bit_in;
            if (in_field(pos_r, `PDCL_POS_FILT_FIRST, `PDCL_POS_FILT_LAST))
                tx_timing_r.filt_char <=
                    {tx_timing_r.filt_char[0], bit_in};
            if (in_field(pos_r, `PDCL_POS_THR_FIRST, `PDCL_POS_THR_LAST))
                tx_timing_r.thr <= {tx_timing_r.thr[1:0], bit_in};
        end
    end

    // address storage; zero-filler clocks are simply not stored
    logic [17:0] addr_r [`PDCL_ADDR_SLOTS];

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            for (int i = 0; i < `PDCL_ADDR_SLOTS; i++)
                addr_r[i] <= 18'h0_0000;
        end else if (take) begin
            for (int i = 0; i < `PDCL_ADDR_SLOTS; i++) begin
                if (in_field(pos_r,
                        8'(`PDCL_POS_ADDR_BASE + 8'(i) * `PDCL_ADDR_STRIDE),
                        8'(`PDCL_POS_ADDR_BASE + 8'(i) * `PDCL_ADDR_STRIDE
                           + `PDCL_ADDR_BITS - 8'h01)))
                    addr_r[i] <= {addr_r[i][16:0], bit_in};
            end
        end
    end

    // effective timing: preset image or transmitted fields
    pdcl_timing_t eff_timing_r;

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            eff_timing_r <= '0;
        end else if (preset_en_r) begin
            eff_timing_r <= preset_lookup({sel_r, low_rate_r});
        end else begin
            eff_timing_r <= tx_timing_r;
        end
    end

    // polarity applied to the synchronised radio input
    logic sig_r;
    always_ff @(posedge mclk_in) begin
        if (reset_in)
            sig_r <= 1'b0;
        else
            sig_r <= sig_sync_r[1] ^ invert_r;
    end

    assign config_done_out           = (state_r == PDCL_DONE);
    assign preset_enable_out         = preset_en_r;
    assign preset_select_hi_out      = sel_r[1];
    assign preset_select_lo_out      = sel_r[0];
    assign low_rate_select_out       = low_rate_r;
    assign frame_slot_number_out     = slot_r;
    assign input_polarity_invert_out = invert_r;
    assign dc_adjust_output_out      = dc_mode_r;
    assign pll_lead_time_out         = eff_timing_r.pll;
    assign rf_lead_time_out          = eff_timing_r.rf;
    assign filter_enable_out         = eff_timing_r.filt_en;
    assign filter_characteristic_out = eff_timing_r.filt_char;
    assign rate_error_threshold_out  = eff_timing_r.thr;
    assign radio_signal_decode_out   = sig_r;
    assign address_slot_a_out        = addr_r[0];
    assign address_slot_b_out        = addr_r[1];
    assign address_slot_c_out        = addr_r[2];
    assign address_slot_d_out        = addr_r[3];
    assign address_slot_e_out        = addr_r[4];
    assign address_slot_f_out        = addr_r[5];

    // checks
    AST_DONE_AFTER_LAST: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (take && last_bit) |=> config_done_out)
        else $error("frame end did not finish loading");
    AST_DONE_HOLDS: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        config_done_out |=> config_done_out)
        else $error("done dropped");
    AST_NOT_DONE_EARLY: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (state_r == PDCL_LOAD && !(take && last_bit)) |=> !config_done_out)
        else $error("done before last bit");
    AST_PRESET_EN: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (take && pos_r == `PDCL_POS_PRESET_EN)
        |=> preset_en_r == $past(bit_in))
        else $error("preset enable not captured");
    AST_LOW_RATE: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (take && pos_r == `PDCL_POS_LOW_RATE)
        |=> low_rate_r == $past(bit_in))
        else $error("rate bit not captured");
    AST_INVERT: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        1'b1 |=> radio_signal_decode_out ==
        ($past(sig_sync_r[1]) ^ $past(invert_r)))
        else $error("polarity wrong");
    AST_PRESET_FORCE: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (preset_en_r && $stable(preset_en_r) && $stable(sel_r)
        && $stable(low_rate_r)) |=> {pll_lead_time_out, rf_lead_time_out,
        filter_enable_out, filter_characteristic_out,
        rate_error_threshold_out} == preset_lookup({$past(sel_r),
        $past(low_rate_r)}))
        else $error("preset not applied");
    AST_TX_USED: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        !preset_en_r |=> rf_lead_time_out == $past(tx_timing_r.rf))
        else $error("transmitted rf lead not used");
    AST_POS_STEP: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (take && !last_bit) |=> pos_r == $past(pos_r) + 8'h01)
        else $error("position did not advance");
    // filler clocks behind the first address must leave it alone
    AST_FILLER_KEEPS: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (take && in_field(pos_r, `PDCL_POS_ADDR_BASE + `PDCL_ADDR_BITS,
        `PDCL_POS_ADDR_BASE + `PDCL_ADDR_STRIDE - 8'h01))
        |=> $stable(address_slot_a_out))
        else $error("filler bit stored");
    // load clocks after the frame are refused
    AST_IGNORE_AFTER: assert property (
        @(posedge mclk_in) disable iff (reset_in)
        (config_done_out && sample_edge) |=> $stable(address_slot_f_out)
        && $stable(frame_slot_number_out))
        else $error("clock after frame changed a field");

endmodule : pdcl_config_loader

// File: pdcl_host_model.sv
`timescale 1ns/1ps
// host side of the serial configuration link
module pdcl_host_model (
    input  wire logic mclk_in,
    output logic      load_clk_out,
    output logic      load_data_out
);
    // link idles with clock low between frames
    initial begin
        load_clk_out  = 1'b0;
        load_data_out = 1'b0;
    end

    // sends the top n bits, msb first, 64 ns per load clock
    task automatic send_bits(input logic [224:0] frame, input int n);
        for (int i = 224; i > 224 - n; i--) begin
            load_data_out = frame[i];
            repeat (4) @(negedge mclk_in);
            load_clk_out = 1'b1;
            repeat (4) @(negedge mclk_in);
            load_clk_out = 1'b0;
        end
        // hold ends: flip data so a stale bit never looks valid
        repeat (4) @(negedge mclk_in);
        load_data_out = ~load_data_out;
        // one more edge so a following call never drives data twice at once
        @(negedge mclk_in);
    endtask : send_bits
endmodule : pdcl_host_model

// File: tb_pdcl_config_loader.sv
`timescale 1ns/1ps
module tb_pdcl_config_loader;
    logic        mclk_in = 1'b0;
    logic        reset_in;
    logic        radio_signal_input_in;
    logic        load_clk_in, load_data_in, radio_signal_decode_out;
    logic        config_done_out, preset_enable_out, preset_select_hi_out;
    logic        preset_select_lo_out, low_rate_select_out;
    logic        input_polarity_invert_out, dc_adjust_output_out;
    logic        filter_enable_out;
    logic [2:0]  frame_slot_number_out, rate_error_threshold_out;
    logic [5:0]  pll_lead_time_out, rf_lead_time_out;
    logic [1:0]  filter_characteristic_out;
    logic [17:0] address_slot_a_out, address_slot_b_out, address_slot_c_out;
    logic [17:0] address_slot_d_out, address_slot_e_out, address_slot_f_out;
    int          error_cnt = 0;
    int          n_compared = 0;
    // preset images {pll,rf,filt_en,filt_char,thr}, index {hi,lo,rate}
    localparam logic [17:0] PRESET [8] = '{18'h3D2A9, 18'h1B129, 18'h3D329,
        18'h1B169, 18'h3D3A9, 18'h1B1A9, 18'h3D441, 18'h1B1C1};
    localparam logic [17:0] ADDR [6] = '{18'h20001, 18'h3FFFE, 18'h12345,
        18'h0ABCD, 18'h25A5A, 18'h00001};

    // grouped views of the outputs for compact comparisons
    wire logic [8:0]   flags_w = {preset_enable_out, preset_select_hi_out,
        preset_select_lo_out, low_rate_select_out, frame_slot_number_out,
        input_polarity_invert_out, dc_adjust_output_out};
    wire logic [17:0]  timing_w = {pll_lead_time_out, rf_lead_time_out,
        filter_enable_out, filter_characteristic_out,
        rate_error_threshold_out};
    wire logic [107:0] addr_all = {address_slot_a_out, address_slot_b_out,
        address_slot_c_out, address_slot_d_out, address_slot_e_out,
        address_slot_f_out};
    wire logic [17:0]  dec_w = {17'h0_0000, radio_signal_decode_out};

    pdcl_config_loader i_pdcl_config_loader (
        .mclk_in, .reset_in, .load_clk_in, .load_data_in,
        .radio_signal_input_in, .config_done_out, .preset_enable_out,
        .preset_select_hi_out, .preset_select_lo_out, .low_rate_select_out,
        .frame_slot_number_out, .input_polarity_invert_out,
        .dc_adjust_output_out, .pll_lead_time_out, .rf_lead_time_out,
        .filter_enable_out, .filter_characteristic_out,
        .rate_error_threshold_out, .radio_signal_decode_out,
        .address_slot_a_out, .address_slot_b_out, .address_slot_c_out,
        .address_slot_d_out, .address_slot_e_out, .address_slot_f_out
    );

    pdcl_host_model i_pdcl_host_model (
        .mclk_in       (mclk_in),
        .load_clk_out  (load_clk_in),
        .load_data_out (load_data_in)
    );

    // 125 mhz system clock
    always #4 mclk_in = ~mclk_in;

    task automatic chk(input logic [17:0] got, input logic [17:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask : chk

    // flag word in load clock order, clock 1 at the top
    function automatic logic [30:0] fl_of(input logic pre,
        input logic [2:0] sel, input logic [2:0] slot, input logic input_polarity_invert,
        input logic dc, input logic [17:0] tm);
        fl_of = {1'b0, pre, sel, slot, input_polarity_invert, dc, 3'b000, tm};
    endfunction : fl_of

    // whole frame: flags, one zero, then six 32-clock address words, then one zero
    function automatic logic [224:0] mk(input logic [30:0] fl);
        mk = {fl, 1'b0, ADDR[0], 14'h0000, ADDR[1], 14'h0000, ADDR[2],
              14'h0000, ADDR[3], 14'h0000, ADDR[4], 14'h0000, ADDR[5],
              14'h0000, 1'b0};
    endfunction : mk

    task automatic do_reset();
        @(negedge mclk_in);
        reset_in = 1'b1;
        repeat (6) @(negedge mclk_in);
        reset_in = 1'b0;
        repeat (2) @(negedge mclk_in);
        // leftovers of an earlier or cut frame must be gone
        chk(18'(flags_w), 18'h0_0000, "reset flags");
        chk(timing_w, 18'h0_0000, "reset timing");
        chk(addr_all[107:90], 18'h0_0000, "reset addr");
        chk(18'(config_done_out), 18'h0_0000, "reset done");
    endtask : do_reset

    // bounded wait, then let the lagging timing outputs settle
    task automatic wait_done();
        int k;
        k = 0;
        while (config_done_out !== 1'b1 && k < 20) begin
            @(negedge mclk_in);
            k++;
        end
        chk(18'(config_done_out), 18'h00001, "done");
        repeat (3) @(negedge mclk_in);
    endtask : wait_done

    task automatic run_frame(input logic [30:0] fl);
        do_reset();
        i_pdcl_host_model.send_bits(mk(fl), 225);
        wait_done();
    endtask : run_frame

    task automatic check_fields(input logic [30:0] fl, input logic [17:0] tm);
        logic [17:0] pol;
        chk(18'(flags_w), 18'(fl[29:21]), "flags");
        chk(timing_w, tm, "timing");
        for (int k = 0; k < 6; k++)
            chk(addr_all[107-18*k -: 18], ADDR[k], "address");
        // concatenation keeps the inversion to one bit
        pol = {17'h0_0000, ~fl[22]};
        radio_signal_input_in = 1'b1;
        repeat (5) @(negedge mclk_in);
        chk(dec_w, pol, "pol");
        pol = {17'h0_0000, fl[22]};
        radio_signal_input_in = 1'b0;
        repeat (5) @(negedge mclk_in);
        chk(dec_w, pol, "pol");
    endtask : check_fields

    // preset off: every field as sent, done only on the last clock
    task automatic t_direct();
        logic [30:0] fl;
        fl = fl_of(1'b0, 3'b101, 3'b101, 1'b1, 1'b1, 18'h2B5B6);
        do_reset();
        i_pdcl_host_model.send_bits(mk(fl), 224);
        chk(18'(config_done_out), 18'h00000, "early done");
        i_pdcl_host_model.send_bits(mk(fl) << 224, 1);
        wait_done();
        check_fields(fl, 18'h2B5B6);
        // extra clocks after the frame must change nothing
        i_pdcl_host_model.send_bits(~mk(fl), 40);
        check_fields(fl, 18'h2B5B6);
        $display("test direct done");
    endtask : t_direct

    // preset on: all eight selections override the sent timing fields
    task automatic t_presets();
        logic [30:0] fl;
        do_reset();
        fl = fl_of(1'b0, 3'b000, 3'b111, 1'b0, 1'b0, 18'h3FFFF);
        i_pdcl_host_model.send_bits(~mk(fl), 100);
        for (int i = 0; i < 8; i++) begin
            fl = fl_of(1'b1, 3'(i), 3'(7 - i), 1'b0, 1'(i), ~PRESET[i]);
            run_frame(fl);
            check_fields(fl, PRESET[i]);
        end
        $display("test presets done");
    endtask : t_presets

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    // main sequence
    initial begin
        reset_in = 1'b1;
        radio_signal_input_in = 1'b0;
        repeat (6) @(negedge mclk_in);
        reset_in = 1'b0;
        t_direct();
        t_presets();
        finish_test();
    end

    // nine frames need about 150 us; allow double
    initial begin
        #300000;
        error_cnt++;
        $display("MISMATCH at %0t: run hung", $time);
        finish_test();
    end
endmodule : tb_pdcl_config_loader
